// >>> logic/lcd_port_defines.svh
// Constants for the enable-strobe LCD port: size codes, phase counts, lane layout.
// Assumes inclusion by bare name from any file of the port that needs them.
`ifndef LCD_PORT_DEFINES_SVH
`define LCD_PORT_DEFINES_SVH

// Transfer sizing codes on req_size_in
`define SIZE_NATIVE      2'h0
`define SIZE_32X16       2'h1
`define SIZE_16X8        2'h2
`define SIZE_32X8        2'h3

// Narrow phases per host transfer
`define PHASES_ONE       3'h1
`define PHASES_TWO       3'h2
`define PHASES_FOUR      3'h4

// Host word, pin bus and byte lane layout
`define HOST_W           32
`define PIN_W            16
`define LANE_W           8
`define LANES            4
`define LANE_ZERO        8'h00

// Lead counter value on the cycle that launches chip select
`define LEAD_LAST        1

// Smallest wait-state field width the sequencer can serve
`define WS_W_MIN         2

`endif

// >>> logic/lcd_port_pkg.sv
// Types shared by the enable-strobe LCD port modules.
// Assumes lcd_port_defines.svh is visible to the modules that use the size codes.
`default_nettype none

package lcd_port_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LEAD,
		ST_ACTIVE
	} seq_state_t;

	// Sizing code carried with a request
	typedef logic [1:0] bus_size_t;

endpackage

`default_nettype wire

// >>> logic/phase_timer_if.sv
// Carrier between the port sequencer and its per-phase strobe timer.
// Assumes one clock; the sequencer owns start and settings, the timer owns position.
`timescale 1ns/1ns
`default_nettype none

interface phase_timer_if #(
	parameter int WS_W = 4
);
	logic             start;
	logic [2:0]       bus_phase_count;
	logic [WS_W-1:0]  total;
	logic [WS_W-1:0]  setup;
	logic [WS_W-1:0]  pulse;
	logic             run;
	logic [WS_W-1:0]  t;
	logic [1:0]       phase;
	logic             e_high;
	logic             e_fall_cycle;
	logic             phase_end;
	logic             xfer_end;

	modport ctrl (
		output start, bus_phase_count, total, setup, pulse,
		input  run, t, phase, e_high, e_fall_cycle, phase_end, xfer_end
	);

	modport timer (
		input  start, bus_phase_count, total, setup, pulse,
		output run, t, phase, e_high, e_fall_cycle, phase_end, xfer_end
	);
endinterface

`default_nettype wire

// >>> logic/strobe_phase_timer.sv
// Per-phase position counter for the enable-strobe LCD port.
// Assumes start comes only while idle and settings hold steady while running.
`timescale 1ns/1ns
`default_nettype none

module strobe_phase_timer #(
	parameter int WS_W = 4
) (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	phase_timer_if.timer     tif
);
	logic             run_r;
	logic [WS_W-1:0]  t_r;
	logic [1:0]       phase_r;
	logic [WS_W:0]    t_wide;
	logic [WS_W:0]    fall_at;

	// Chip select window: one start, ends after the last phase
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			run_r <= 1'h0;
		end else if (tif.start) begin
			run_r <= 1'h1;
		end else if (tif.xfer_end) begin
			run_r <= 1'h0;
		end
	end

	// Position inside a phase, each phase total+1 periods long
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			t_r <= '0;
		end else if (tif.start || tif.phase_end) begin
			t_r <= '0;
		end else if (run_r) begin
			t_r <= WS_W'(t_r + 1'h1);
		end
	end

	// Phase index advances when a phase wraps
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_r <= '0;
		end else if (tif.start) begin
			phase_r <= '0;
		end else if (tif.phase_end) begin
			phase_r <= 2'(phase_r + 1'h1);
		end
	end

	// Strobe window set-up..set-up+pulse-1; widened so the sum cannot wrap
	assign t_wide           = {1'h0, t_r};
	assign fall_at          = WS_W'(0) + {1'h0, tif.setup} + {1'h0, tif.pulse};
	assign tif.run          = run_r;
	assign tif.t            = t_r;
	assign tif.phase        = phase_r;
	assign tif.e_high       = run_r && (t_wide >= {1'h0, tif.setup}) && (t_wide < fall_at);
	assign tif.e_fall_cycle = run_r && (tif.pulse != '0) && (t_wide == (fall_at - 1'h1));
	assign tif.phase_end    = run_r && (t_r == tif.total);
	assign tif.xfer_end     = tif.phase_end && ((3'(phase_r) + 3'h1) == tif.bus_phase_count);

endmodule // strobe_phase_timer

`default_nettype wire

// >>> logic/lcd_strobe_port.sv
// Enable-strobe (read/write line plus enable) parallel LCD port sequencer.
// Assumes synchronous request inputs; wait-state settings are sampled when a request is taken.
// External bus keepers hold the data pins once lcd_data_oe_out drops.
`timescale 1ns/1ns
`default_nettype none

`include "lcd_port_defines.svh"

module lcd_strobe_port
	import lcd_port_pkg::*;
#(
	parameter int WS_W   = 4,
	parameter int LEAD_W = 4,
	parameter int ADDR_W = 8
) (
	input  wire logic                clk_in,
	input  wire logic                arst_n_in,
	input  wire logic                req_valid_in,
	output logic                     req_ready_out,
	input  wire logic                req_write_in,
	input  wire bus_size_t           req_size_in,
	input  wire logic                req_rs_in,
	input  wire logic [ADDR_W-1:0]   req_addr_in,
	input  wire logic [`HOST_W-1:0]  req_wdata_in,
	input  wire logic [WS_W-1:0]     total_ws_in,
	input  wire logic [WS_W-1:0]     setup_ws_in,
	input  wire logic [WS_W-1:0]     pulse_ws_in,
	input  wire logic [LEAD_W-1:0]   select_lead_in,
	output logic                     done_out,
	output logic [`HOST_W-1:0]       rdata_out,
	output logic                     lcd_cs_n_out,
	output logic                     register_select_line_out,
	output logic [ADDR_W-1:0]        lcd_addr_out,
	output logic                     lcd_e_out,
	output logic                     lcd_rw_out,
	output logic [`PIN_W-1:0]        lcd_data_out,
	output logic                     lcd_data_oe_out,
	input  wire logic [`PIN_W-1:0]   lcd_data_in
);
	localparam int LEAD_CNT_W = LEAD_W + 3;

	// Refuse widths the counters cannot serve
	if (WS_W < `WS_W_MIN) begin : g_ws_check
		$error("WS_W too small for strobe placement");
	end
	if (LEAD_W < 1 || ADDR_W < 1) begin : g_w_check
		$error("LEAD_W and ADDR_W must be at least one bit");
	end

	seq_state_t               state_r;
	logic                     write_r;
	bus_size_t                size_r;
	logic                     rs_r;
	logic [ADDR_W-1:0]        addr_r;
	logic [`HOST_W-1:0]       wdata_r;
	logic [WS_W-1:0]          total_r;
	logic [WS_W-1:0]          setup_r;
	logic [WS_W-1:0]          pulse_r;
	logic [2:0]               bus_phase_count_r;
	logic [2:0]               bus_phase_count_nxt;
	logic [LEAD_CNT_W-1:0]    lead_cnt_r;
	logic [LEAD_CNT_W-1:0]    lead_nxt;
	logic                     select_valid_r;
	logic [`PIN_W-1:0]        data_r;
	logic                     done_r;
	logic                     accept;
	logic                     launch;
	logic                     narrow8_r;
	logic                     narrow8_cur;
	logic [`HOST_W-1:0]       wdata_cur;
	logic [1:0]               data_phase;
	logic                     first_cycle;
	logic                     last_cycle;

	phase_timer_if #(.WS_W(WS_W)) tif ();

	strobe_phase_timer #(
		.WS_W (WS_W)
	) u_timer (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.tif       (tif)
	);

	// Phase count from the sizing code of the incoming request
	always_comb begin
		case (req_size_in)
			`SIZE_NATIVE: bus_phase_count_nxt = `PHASES_ONE;
			`SIZE_32X16:  bus_phase_count_nxt = `PHASES_TWO;
			`SIZE_16X8:   bus_phase_count_nxt = `PHASES_TWO;
			`SIZE_32X8:   bus_phase_count_nxt = `PHASES_FOUR;
			default:      bus_phase_count_nxt = `PHASES_ONE;
		endcase
	end

	// Select lead scales with the phase count, as the select window does
	assign lead_nxt = LEAD_CNT_W'(select_lead_in) * LEAD_CNT_W'(bus_phase_count_nxt);

	// Request taken only when idle; ready is the handshake
	assign req_ready_out = (state_r == ST_IDLE);
	assign accept        = req_ready_out && req_valid_in;

	// Chip select launch: at once with no lead, else when the lead runs out
	assign launch = (accept && (lead_nxt == '0))
		|| ((state_r == ST_LEAD) && (lead_cnt_r == LEAD_CNT_W'(`LEAD_LAST)));

	// Settings go to the timer from the latched copy
	assign tif.start           = launch;
	assign tif.bus_phase_count = bus_phase_count_r;
	assign tif.total           = total_r;
	assign tif.setup           = setup_r;
	assign tif.pulse           = pulse_r;

	// Sequencer: idle, select lead, chip select window
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						state_r <= (lead_nxt == '0) ? ST_ACTIVE : ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (launch) begin
						state_r <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					if (tif.xfer_end) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Lead countdown; select leads chip select by exactly this many periods
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lead_cnt_r <= '0;
		end else if (accept) begin
			lead_cnt_r <= lead_nxt;
		end else if (state_r == ST_LEAD) begin
			lead_cnt_r <= LEAD_CNT_W'(lead_cnt_r - 1'h1);
		end
	end

	// Request capture; settings are frozen for the whole transfer
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			write_r           <= 1'h0;
			size_r            <= `SIZE_NATIVE;
			rs_r              <= 1'h0;
			addr_r            <= '0;
			wdata_r           <= '0;
			total_r           <= '0;
			setup_r           <= '0;
			pulse_r           <= '0;
			bus_phase_count_r <= `PHASES_ONE;
		end else if (accept) begin
			write_r           <= req_write_in;
			size_r            <= req_size_in;
			rs_r              <= req_rs_in;
			addr_r            <= req_addr_in;
			wdata_r           <= req_wdata_in;
			total_r           <= total_ws_in;
			setup_r           <= setup_ws_in;
			pulse_r           <= pulse_ws_in;
			bus_phase_count_r <= bus_phase_count_nxt;
		end
	end

	// Register select window: from accept to the edge that drops chip select; the address holds until the next accept
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			select_valid_r <= 1'h0;
		end else if (accept) begin
			select_valid_r <= 1'h1;
		end else if (tif.xfer_end) begin
			select_valid_r <= 1'h0;
		end
	end

	// Completion pulse, raised on the same edge that releases chip select
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			done_r <= 1'h0;
		end else begin
			done_r <= (state_r == ST_ACTIVE) && tif.xfer_end;
		end
	end

	// Byte-wide phases for the two 8-bit sizings
	assign narrow8_r   = (size_r == `SIZE_16X8) || (size_r == `SIZE_32X8);
	assign narrow8_cur = (state_r == ST_IDLE)
		? ((req_size_in == `SIZE_16X8) || (req_size_in == `SIZE_32X8)) : narrow8_r;
	// Launch from idle sees the request word before it is latched
	assign wdata_cur   = (state_r == ST_IDLE) ? req_wdata_in : wdata_r;
	assign data_phase  = launch ? 2'h0 : 2'(tif.phase + 1'h1);

	// Narrow slice of the host word for one phase, low part first
	function automatic logic [`PIN_W-1:0] phase_slice(
		input logic [`HOST_W-1:0] word,
		input logic [1:0]         k,
		input logic               narrow8
	);
		logic [`HOST_W-1:0] shifted;
		shifted = narrow8 ? (word >> {k, 3'h0}) : (word >> {k[0], 4'h0});
		return narrow8 ? {`LANE_ZERO, shifted[`LANE_W-1:0]} : shifted[`PIN_W-1:0];
	endfunction

	// Write data loads with chip select and at each phase boundary
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			data_r <= '0;
		end else if (launch) begin
			data_r <= phase_slice(wdata_cur, data_phase, narrow8_cur);
		end else if (tif.phase_end && !tif.xfer_end) begin
			data_r <= phase_slice(wdata_r, data_phase, narrow8_r);
		end
	end

	// First and last period of the chip select window
	assign first_cycle = tif.run && (tif.phase == 2'h0) && (tif.t == '0);
	assign last_cycle  = tif.xfer_end;

	// Read lanes: each byte captured on the enable fall of its own phase
	for (genvar j = 0; j < `LANES; j++) begin : g_lane
		localparam logic [1:0] SEL8  = 2'(j);
		localparam logic [1:0] SEL16 = 2'(j / 2);
		localparam int         PB16  = j % 2;
		logic [`LANE_W-1:0] lane_r;
		logic               hit;

		assign hit = tif.e_fall_cycle && !write_r
			&& (tif.phase == (narrow8_r ? SEL8 : SEL16));

		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				lane_r <= `LANE_ZERO;
			end else if (launch) begin
				lane_r <= `LANE_ZERO; // Lanes a sizing never fills read zero
			end else if (hit) begin
				// Sampled on the edge where enable falls
				lane_r <= narrow8_r ? lcd_data_in[`LANE_W-1:0]
					: lcd_data_in[PB16*`LANE_W +: `LANE_W];
			end
		end

		assign rdata_out[j*`LANE_W +: `LANE_W] = lane_r;
	end

	// Pin drive; strobes decode straight from timer flops, so no extra lag
	assign lcd_cs_n_out             = ~tif.run;
	assign register_select_line_out = select_valid_r & rs_r;
	assign lcd_addr_out             = addr_r;
	assign lcd_e_out                = tif.e_high;
	// Reads never pull the direction line low; writes skip first and last period
	assign lcd_rw_out               = ~(write_r && tif.run && !first_cycle && !last_cycle);
	assign lcd_data_out             = data_r;
	// Keepers take over in the final period, phases in between keep driving
	assign lcd_data_oe_out          = write_r && tif.run && !last_cycle;
	assign done_out                 = done_r;

	// The behaviour falls out of the direction decode above
	// high for reads, high again on the last chip select period of a write.
	// Strobe spacing between phases follows from the wrap of the timer.

endmodule // lcd_strobe_port

`default_nettype wire

// >>> test/lcd_strobe_port_props.sv
// Timing checker for the enable-strobe LCD port.
// Assumes binding to lcd_strobe_port and sight of its ports only.
`timescale 1ns/1ns
`default_nettype none
`include "lcd_port_defines.svh"
module lcd_strobe_port_props
	import lcd_port_pkg::*;
#(
	parameter int WS_W   = 4,
	parameter int LEAD_W = 4
) (
	input wire logic               clk_in,
	input wire logic               arst_n_in,
	input wire logic               req_valid_in,
	input wire logic               req_ready_out,
	input wire logic               req_write_in,
	input wire bus_size_t          req_size_in,
	input wire logic               req_rs_in,
	input wire logic [`HOST_W-1:0] req_wdata_in,
	input wire logic [WS_W-1:0]    total_ws_in,
	input wire logic [WS_W-1:0]    setup_ws_in,
	input wire logic [WS_W-1:0]    pulse_ws_in,
	input wire logic [LEAD_W-1:0]  select_lead_in,
	input wire logic               done_out,
	input wire logic [`HOST_W-1:0] rdata_out,
	input wire logic               lcd_cs_n_out,
	input wire logic               register_select_line_out,
	input wire logic               lcd_e_out,
	input wire logic               lcd_rw_out,
	input wire logic [`PIN_W-1:0]  lcd_data_out,
	input wire logic               lcd_data_oe_out,
	input wire logic [`PIN_W-1:0]  lcd_data_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	logic              wr_r, rs_r;
	bus_size_t         sz_r;
	logic [WS_W-1:0]   n_r, s_r, p_r;
	logic [LEAD_W-1:0] l_r;
	logic [31:0]       wd_r, rd_r;
	logic [15:0]       exp_wd;
	int                cnt_r, lead_r, bp, ph, k, last;
	// Settings as taken; read lanes filled on every strobe-high edge, last one wins
	always_ff @(posedge clk_in) begin
		if (req_valid_in && req_ready_out) begin
			{wr_r, rs_r, sz_r, wd_r} <= {req_write_in, req_rs_in, req_size_in, req_wdata_in};
			{n_r, s_r, p_r, l_r} <= {total_ws_in, setup_ws_in, pulse_ws_in, select_lead_in};
			rd_r <= '0;
		end else if (lcd_e_out && !wr_r) begin
			if (sz_r == `SIZE_NATIVE || sz_r == `SIZE_32X16) rd_r[16*k+:16] <= lcd_data_in;
			else rd_r[8*k+:8] <= lcd_data_in[7:0];
		end
	end
	// Window position and lead length, both cleared by the pins themselves
	always_ff @(posedge clk_in) begin
		cnt_r <= lcd_cs_n_out ? 0 : cnt_r + 1;
		lead_r <= (!req_ready_out && lcd_cs_n_out) ? lead_r + 1 : 0;
	end
	// Phase figures derived from the taken settings
	always_comb begin
		bp = (sz_r == `SIZE_NATIVE) ? 1 : (sz_r == `SIZE_32X8) ? 4 : 2;
		ph = cnt_r % (int'(n_r) + 1);
		k = cnt_r / (int'(n_r) + 1);
		last = bp * (int'(n_r) + 1) - 1;
		if (sz_r == `SIZE_NATIVE) exp_wd = wd_r[15:0];
		else if (sz_r == `SIZE_32X16) exp_wd = wd_r[16*k+:16];
		else exp_wd = {`LANE_ZERO, wd_r[8*k+:8]};
	end
	sequence cs_release;
		$rose(lcd_cs_n_out);
	endsequence
	sequence done_pulse;
		done_out ##1 !done_out;
	endsequence
	AST_CS_LEN: assert property (cs_release |-> cnt_r == last + 1)
		else $error("chip select length off");
	AST_DONE: assert property (cs_release |-> done_pulse)
		else $error("done not a single pulse at release");
	AST_LEAD: assert property ($fell(lcd_cs_n_out) |-> lead_r == bp * int'(l_r))
		else $error("select lead off");
	AST_RS: assert property (register_select_line_out == (!req_ready_out && rs_r))
		else $error("select line wrong");
	AST_E_WIN: assert property (lcd_e_out == (!lcd_cs_n_out && ph >= s_r && ph < s_r + p_r))
		else $error("enable strobe misplaced");
	AST_RW: assert property (lcd_rw_out == !(wr_r && !lcd_cs_n_out && cnt_r >= 1 && cnt_r < last))
		else $error("direction line wrong");
	AST_OE: assert property (lcd_data_oe_out == (wr_r && !lcd_cs_n_out && cnt_r < last))
		else $error("data drive window wrong");
	AST_WDATA: assert property (lcd_data_oe_out |-> lcd_data_out == exp_wd)
		else $error("write lane wrong");
	AST_RDATA: assert property (done_out && !wr_r |-> rdata_out == rd_r)
		else $error("read word wrong");
endmodule // lcd_strobe_port_props
`default_nettype wire

// >>> test/lcd_panel_model.sv
// Behavioural LCD controller on the far side of the strobe port.
// Assumes the port's pins; written words are queued for the bench.
`timescale 1ns/1ns
`default_nettype none
module lcd_panel_model (
	input  wire logic        clk_in,
	input  wire logic        cs_n_in,
	input  wire logic        e_in,
	input  wire logic        rw_in,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out
);
	logic [15:0] seq_r = 16'h8421;
	logic [15:0] cyc_r = 16'h0000;
	logic [15:0] wl_r;
	logic        e_d_r = 1'b0;
	logic        wr_d_r = 1'b0;
	logic [15:0] wq [$];
	// Word only while strobed for read; churns otherwise so stale data never passes
	assign data_out = (!cs_n_in && rw_in && e_in) ? seq_r : ~seq_r ^ cyc_r;
	// Writes latched at the strobe fall; read pattern steps after each read strobe
	always @(posedge clk_in) begin
		cyc_r <= cyc_r + 16'h0001;
		e_d_r <= e_in;
		wr_d_r <= e_in && !rw_in;
		if (e_in) wl_r <= data_in;
		if (e_d_r && !e_in && wr_d_r) wq.push_back(wl_r);
		if (e_d_r && !e_in && !wr_d_r) seq_r <= seq_r + 16'h1357;
	end
endmodule // lcd_panel_model
`default_nettype wire

// >>> test/lcd_strobe_port_test.sv
// Self-checking bench for the enable-strobe LCD port.
// Assumes the port, its checker and the panel model; one 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "lcd_port_defines.svh"
module lcd_strobe_port_test
	import lcd_port_pkg::*;
;
	typedef struct {
		logic        wr;
		bus_size_t   sz;
		int          n, s, p, l, cyc;
		logic [31:0] wd;
		bit          chain;
	} row_t;
	// Ordinary accesses; set-up plus pulse never above the total
	row_t rows [9] = '{
		'{1, 0, 3, 1, 1, 1, 6, 32'hcafe_1234, 0}, '{0, 0, 3, 1, 1, 1, 6, 32'h0000_0000, 0},
		'{1, 1, 4, 2, 2, 1, 13, 32'h5a5a_0ff0, 0}, '{0, 1, 2, 1, 1, 0, 7, 32'h0000_0000, 0},
		'{1, 2, 2, 1, 1, 2, 11, 32'h0000_9c3e, 0}, '{0, 2, 3, 1, 2, 1, 11, 32'h0000_0000, 0},
		'{1, 3, 2, 1, 1, 1, 17, 32'h8765_4321, 1}, '{0, 3, 3, 2, 1, 1, 21, 32'h0000_0000, 0},
		'{1, 0, 15, 7, 8, 15, 32, 32'h0001_fffe, 0}};
	logic        clk_in, arst_n_in, req_valid_in, req_write_in, req_rs_in;
	bus_size_t   req_size_in;
	logic [7:0]  req_addr_in, lcd_addr_out;
	logic [31:0] req_wdata_in, rdata_out;
	logic [3:0]  total_ws_in, setup_ws_in, pulse_ws_in, select_lead_in;
	logic        req_ready_out, done_out, lcd_cs_n_out, register_select_line_out;
	logic        lcd_e_out, lcd_rw_out, lcd_data_oe_out;
	logic [15:0] lcd_data_out, lcd_data_in, panel_q;
	logic [15:0] rseq = 16'h8421;
	int          fails = 0;
	int          total_checks = 0;
	// Wire level: port drives while enabled, panel otherwise
	assign lcd_data_in = lcd_data_oe_out ? lcd_data_out : panel_q;
	lcd_strobe_port #(.WS_W(4), .LEAD_W(4), .ADDR_W(8)) dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
		.req_ready_out(req_ready_out), .req_write_in(req_write_in), .req_size_in(req_size_in),
		.req_rs_in(req_rs_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.total_ws_in(total_ws_in), .setup_ws_in(setup_ws_in), .pulse_ws_in(pulse_ws_in),
		.select_lead_in(select_lead_in), .done_out(done_out), .rdata_out(rdata_out),
		.lcd_cs_n_out(lcd_cs_n_out), .register_select_line_out(register_select_line_out),
		.lcd_addr_out(lcd_addr_out), .lcd_e_out(lcd_e_out), .lcd_rw_out(lcd_rw_out),
		.lcd_data_out(lcd_data_out), .lcd_data_oe_out(lcd_data_oe_out), .lcd_data_in(lcd_data_in));
	lcd_panel_model partner (.clk_in(clk_in), .cs_n_in(lcd_cs_n_out), .e_in(lcd_e_out),
		.rw_in(lcd_rw_out), .data_in(lcd_data_in), .data_out(panel_q));
	// 50 ns period
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task automatic check(input logic ok, input string what);
		total_checks++;
		if (!ok) begin
			fails++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] lane(input logic [31:0] w, input bus_size_t sz, input int k);
		if (sz == `SIZE_NATIVE) return w[15:0];
		if (sz == `SIZE_32X16) return w[16*k+:16];
		return {8'h00, w[8*k+:8]};
	endfunction
	// Request held from here until the edge that takes it
	task automatic set_req(input int i);
		req_valid_in <= 1'b1;
		{req_write_in, req_size_in, req_wdata_in} <= {rows[i].wr, rows[i].sz, rows[i].wd};
		{req_rs_in, req_addr_in} <= {i[0], i[7:0]};
		{total_ws_in, setup_ws_in} <= {rows[i].n[3:0], rows[i].s[3:0]};
		{pulse_ws_in, select_lead_in} <= {rows[i].p[3:0], rows[i].l[3:0]};
	endtask
	// Entered at a falling edge; returns at the falling edge of the done cycle
	task automatic run(input int i);
		int c;
		int bp;
		logic [31:0] ex;
		c = 0;
		bp = (rows[i].sz == `SIZE_NATIVE) ? 1 : (rows[i].sz == `SIZE_32X8) ? 4 : 2;
		ex = '0;
		while (req_ready_out !== 1'b1 && c < 99) begin
			@(negedge clk_in);
			c++;
		end
		if (c >= 99) begin
			fails++;
			finish_test();
		end
		@(posedge clk_in);
		if (rows[i].chain) set_req(i + 1);
		else req_valid_in <= 1'b0;
		c = 0;
		do begin
			@(negedge clk_in);
			c++;
		end while (done_out !== 1'b1 && c < 200);
		if (c >= 200) begin
			fails++;
			finish_test();
		end
		check(c == rows[i].cyc, "access length");
		check(lcd_addr_out === i[7:0], "address held");
		for (int k = 0; k < bp; k++) begin
			if (rows[i].wr) check(partner.wq.size() > 0 &&
				partner.wq.pop_front() === lane(rows[i].wd, rows[i].sz, k), "write lane");
			else if (rows[i].sz == `SIZE_NATIVE || rows[i].sz == `SIZE_32X16) ex[16*k+:16] = rseq;
			else ex[8*k+:8] = rseq[7:0];
			if (!rows[i].wr) rseq = rseq + 16'h1357;
		end
		if (!rows[i].wr) check(rdata_out === ex, "read word");
		$display("test %0d done", i);
	endtask
	initial begin
		{req_valid_in, req_write_in, req_rs_in, req_size_in, req_addr_in} = '0;
		{req_wdata_in, total_ws_in, setup_ws_in, pulse_ws_in, select_lead_in} = '0;
		arst_n_in = 1'b0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		check({req_ready_out, lcd_cs_n_out, register_select_line_out, lcd_e_out, lcd_rw_out,
			lcd_data_oe_out, done_out, rdata_out} === {7'h64, 32'h0000_0000}, "reset state");
		@(posedge clk_in);
		arst_n_in <= 1'b1;
		set_req(0);
		@(negedge clk_in);
		run(0);
		// Table rows; a chained row is taken on the done cycle of the one before
		for (int i = 1; i < 9; i++) begin
			if (!rows[i - 1].chain) begin
				@(posedge clk_in);
				set_req(i);
				@(negedge clk_in);
			end
			run(i);
		end
		// Reset in mid transfer, then a fresh access at the first edge after release
		@(posedge clk_in);
		set_req(6);
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		arst_n_in <= 1'b0;
		@(negedge clk_in);
		check({req_ready_out, lcd_cs_n_out, register_select_line_out, lcd_e_out, lcd_rw_out,
			lcd_data_oe_out, done_out, rdata_out} === {7'h64, 32'h0000_0000}, "abort state");
		@(posedge clk_in);
		arst_n_in <= 1'b1;
		set_req(0);
		@(negedge clk_in);
		partner.wq.delete();
		$display("test abort done");
		run(0);
		finish_test();
	end
endmodule // lcd_strobe_port_test
bind lcd_strobe_port lcd_strobe_port_props #(.WS_W(WS_W), .LEAD_W(LEAD_W)) props (
	.clk_in(clk_in), .arst_n_in(arst_n_in), .req_valid_in(req_valid_in),
	.req_ready_out(req_ready_out), .req_write_in(req_write_in), .req_size_in(req_size_in),
	.req_rs_in(req_rs_in), .req_wdata_in(req_wdata_in), .total_ws_in(total_ws_in),
	.setup_ws_in(setup_ws_in), .pulse_ws_in(pulse_ws_in), .select_lead_in(select_lead_in),
	.done_out(done_out), .rdata_out(rdata_out), .lcd_cs_n_out(lcd_cs_n_out),
	.register_select_line_out(register_select_line_out), .lcd_e_out(lcd_e_out),
	.lcd_rw_out(lcd_rw_out), .lcd_data_out(lcd_data_out), .lcd_data_oe_out(lcd_data_oe_out),
	.lcd_data_in(lcd_data_in));
`default_nettype wire
